/* File: ube_pkg.sv */
package ube_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_ERR = 8'h08;
  localparam logic [7:0] ADDR_RXBUF = 8'h0c;
  localparam logic [7:0] ADDR_TXBUF = 8'h10;
  localparam logic [7:0] ADDR_CLKSEL = 8'h14;
  localparam logic [7:0] ADDR_DIV = 8'h18;
  localparam logic [7:0] ADDR_TXSTAT = 8'h1c;
  // mode register fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_STOP2 = 2;
  localparam int MODE_MERGE = 0;
  // control register fields
  localparam int CTRL_BRK_FLAG = 7;
  localparam int CTRL_BRK_RX = 6;
  localparam int CTRL_BRK_TX = 5;
  localparam int CTRL_LEN_HI = 4;
  localparam int CTRL_LEN_LO = 2;
  // error status fields
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h14;
  localparam logic [7:0] RXBUF_RST = 8'hff;
  localparam logic [7:0] DIV_RST = 8'hff;
  localparam logic [3:0] CLKSEL_RST = 4'h0;
  // counts
  localparam logic [7:0] DIV_MIN = 8'h08;
  localparam logic [3:0] BRK_RX_MIN = 4'hb;
  localparam logic [3:0] BRK_TX_BASE = 4'h8;
  localparam logic [3:0] DATA_LAST = 4'h7;
  // parity modes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
    RX_PAR = 3'h2, RX_STOP = 3'h6, RX_BRK = 3'h7
  } ube_rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3,
    TX_PAR = 3'h2, TX_STOP = 3'h6, TX_BRK = 3'h4
  } ube_tx_state_t;
endpackage

/* File: ube_rx_filter.sv */
`timescale 1ns/100ps
module ube_rx_filter (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sampling
  input wire logic tick_i,
  input wire logic pin_i,
  output logic level_o
);
  import ube_pkg::*;
  logic sync1_q;
  logic sync2_q;
  logic samp_q;
  logic level_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // level moves only after two agreeing base-clock samples
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_q <= 1'b1;
      level_q <= 1'b1;
    end else if (tick_i) begin
      samp_q <= sync2_q; // R7
      if (sync2_q == samp_q) begin
        level_q <= sync2_q; // R8
      end
    end
  end

  assign level_o = level_q;

  property p_filter;
    @(posedge clk_i) disable iff (rst_i)
      (level_q != $past(level_q)) |-> $past(tick_i) && ($past(samp_q) == level_q);
  endproperty
  filter_match_a: assert property (p_filter) else $error("filter changed without agreeing samples"); // R7
endmodule

/* File: ube_baud_cnt.sv */
`timescale 1ns/100ps
module ube_baud_cnt #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [W-1:0] div_i,
  // half bit period strobe
  output logic half_o
);
  import ube_pkg::*;
  logic [W-1:0] cnt_q;
  logic wrap;

  if (W < 4) begin : g_chk
    $error("baud counter too narrow");
  end

  assign wrap = (cnt_q == div_i - W'(1));
  assign half_o = tick_i & ~clear_i & wrap; // R24

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (clear_i) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      cnt_q <= wrap ? '0 : cnt_q + W'(1);
    end
  end

  cnt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_i |=> cnt_q == '0) else $error("counter not cleared"); // R20
endmodule

/* File: ube_uart.sv */
// How it works
// R1: errors after a frame raise error interrupt
// R2: reading error status clears it to zero
// R3: parity mismatch sets parity error flag
// R4: low stop sample sets framing error
// R5: unread buffer on new frame sets overrun
// R6: merge bit routes errors to receive-done
// R7: filter updates only on two agreeing samples
// R8: receive path lags pin by two ticks
// R9: three-bit field selects break length
// R10: field value 101 gives thirteen bits
// R11: break trigger drives low, then done, clears
// R12: software may stretch break with zero byte
// R13: break receive armed by trigger with enables
// R14: long break raises done, clears both bits
// R15: break reception suppresses all error flags
// R16: break never loads receive buffer
// R17: short break: no interrupt, bits stay set
// R18: clock select picks base clock, power gates
// R19: separate transmit and receive bit counters
// R20: transmit counter cleared unless power and enable
// R21: first buffered byte clears transmit counter
// R22: back-to-back frames reclear counter, else runs
// R23: receive counter held idle between frames
// R24: bit period is twice the divisor
// R25: receiver checks exactly one stop bit
// R26: start accepted only if still low
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
module ube_uart #(
  parameter int DIV_W = 8,
  parameter int PRE_STAGES = 11
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial line
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  // event pulses
  output logic rx_done_irq_o,
  output logic rx_error_irq_o,
  output logic tx_done_irq_o
);
  import ube_pkg::*;

  if (DIV_W != 8 || PRE_STAGES < 2 || PRE_STAGES > 16) begin : g_chk
    $error("unsupported divisor or prescaler width");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [PRE_STAGES-1:0] pre_mask(input logic [3:0] sel);
    pre_mask = '0;
    for (int i = 0; i < PRE_STAGES; i++) begin
      if (i < int'(sel)) begin
        pre_mask[i] = 1'b1;
      end
    end
  endfunction

  logic [7:0] uart_mode_reg_q;
  logic [7:0] uart_control_reg_q;
  logic [2:0] rx_error_status_reg_q;
  logic [7:0] rx_buffer_reg_q;
  logic rx_full_q;
  logic [7:0] tx_buffer_reg_q;
  logic tx_full_q;
  logic [3:0] clock_select_reg_q;
  logic [DIV_W-1:0] divisor_reg_q;
  logic [31:0] prdata_q;
  logic [PRE_STAGES-1:0] pre_cnt_q;

  logic setup, wr, rd;
  logic uart_power_on, tx_en, rx_en, merge;
  logic [1:0] par_mode;
  logic base_tick;

  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;
  assign uart_power_on = uart_mode_reg_q[MODE_POWER];
  assign tx_en = uart_power_on & uart_mode_reg_q[MODE_TXE];
  assign rx_en = uart_power_on & uart_mode_reg_q[MODE_RXE];
  assign merge = uart_mode_reg_q[MODE_MERGE];
  assign par_mode = uart_mode_reg_q[MODE_PAR_HI:MODE_PAR_LO];

  // prescaler: base clock is a one-cycle enable, silent with power off
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_q <= '0;
    end else if (!uart_power_on) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + PRE_STAGES'(1);
    end
  end
  assign base_tick = uart_power_on &&
    ((pre_cnt_q & pre_mask(clock_select_reg_q)) == pre_mask(clock_select_reg_q)); // R18

  // receive side signals
  ube_rx_state_t rx_state_q;
  logic rx_lvl, rx_prev_q, rx_fall, rx_half, rx_sample;
  logic rx_phase_q, rx_par_q, rx_fin, brk_ok, brk_fail;
  logic [3:0] rx_bits_q, brk_low_q;
  logic [7:0] rx_shift_reg_q;
  logic [2:0] rx_err;
  logic pe;

  // transmit side signals
  ube_tx_state_t tx_state_q;
  logic tx_half, tx_bit_end, tx_phase_q, tx_par_q;
  logic tx_load, brk_go, tx_stop_end, tx_done, tx_out;
  logic [3:0] tx_bits_q, brk_len;
  logic [7:0] tx_shift_q;

  ube_rx_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(base_tick),
    .pin_i(serial_in_pin_i),
    .level_o(rx_lvl)
  );

  // R19: two independent counters
  ube_baud_cnt #(.W(DIV_W)) u_rx_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(base_tick),
    .clear_i(~rx_en | (rx_state_q == RX_IDLE)), // R23
    .div_i(divisor_reg_q),
    .half_o(rx_half)
  );

  ube_baud_cnt #(.W(DIV_W)) u_tx_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(base_tick),
    .clear_i(~tx_en | tx_load | brk_go), // R20 R21 R22
    .div_i(divisor_reg_q),
    .half_o(tx_half)
  );

  // apb: zero wait states, read data latched in the setup cycle
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~(hit(paddr_i, ADDR_MODE) | hit(paddr_i, ADDR_CTRL) |
    hit(paddr_i, ADDR_ERR) | hit(paddr_i, ADDR_RXBUF) | hit(paddr_i, ADDR_TXBUF) |
    hit(paddr_i, ADDR_CLKSEL) | hit(paddr_i, ADDR_DIV) | hit(paddr_i, ADDR_TXSTAT));
  assign prdata_o = prdata_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0;
    end else if (setup && !pwrite_i) begin
      if (hit(paddr_i, ADDR_MODE)) begin
        prdata_q <= {24'h0, uart_mode_reg_q};
      end else if (hit(paddr_i, ADDR_CTRL)) begin
        prdata_q <= {24'h0, uart_control_reg_q};
      end else if (hit(paddr_i, ADDR_ERR)) begin
        prdata_q <= {29'h0, rx_error_status_reg_q};
      end else if (hit(paddr_i, ADDR_RXBUF)) begin
        prdata_q <= {24'h0, rx_buffer_reg_q};
      end else if (hit(paddr_i, ADDR_TXBUF)) begin
        prdata_q <= {24'h0, tx_buffer_reg_q};
      end else if (hit(paddr_i, ADDR_CLKSEL)) begin
        prdata_q <= {28'h0, clock_select_reg_q};
      end else if (hit(paddr_i, ADDR_DIV)) begin
        prdata_q <= {24'h0, divisor_reg_q};
      end else if (hit(paddr_i, ADDR_TXSTAT)) begin
        prdata_q <= {30'h0, tx_full_q, tx_state_q != TX_IDLE};
      end else begin
        prdata_q <= 32'h0;
      end
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uart_mode_reg_q <= MODE_RST;
      clock_select_reg_q <= CLKSEL_RST;
      divisor_reg_q <= DIV_RST;
    end else if (wr) begin
      if (hit(paddr_i, ADDR_MODE)) begin
        uart_mode_reg_q <= pwdata_i[7:0] & 8'hfd;
      end else if (hit(paddr_i, ADDR_CLKSEL)) begin
        clock_select_reg_q <= pwdata_i[3:0];
      end else if (hit(paddr_i, ADDR_DIV) && pwdata_i[7:0] >= DIV_MIN) begin
        divisor_reg_q <= pwdata_i[7:0]; // R24
      end
    end
  end

  // control: hardware clears of the break bits follow the software write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      uart_control_reg_q <= CTRL_RST;
    end else begin
      if (wr && hit(paddr_i, ADDR_CTRL)) begin
        uart_control_reg_q[CTRL_LEN_HI:CTRL_LEN_LO] <= pwdata_i[CTRL_LEN_HI:CTRL_LEN_LO]; // R9
        uart_control_reg_q[CTRL_BRK_TX] <= pwdata_i[CTRL_BRK_TX];
        uart_control_reg_q[CTRL_BRK_RX] <= pwdata_i[CTRL_BRK_RX] & rx_en; // R13
        uart_control_reg_q[CTRL_BRK_FLAG] <= pwdata_i[CTRL_BRK_RX] & rx_en;
      end
      if (brk_ok) begin
        uart_control_reg_q[CTRL_BRK_RX] <= 1'b0; // R14
        uart_control_reg_q[CTRL_BRK_FLAG] <= 1'b0;
      end
      if (tx_state_q == TX_BRK && tx_done) begin
        uart_control_reg_q[CTRL_BRK_TX] <= 1'b0; // R11
      end
    end
  end

  // receive framing
  assign rx_fall = rx_prev_q & ~rx_lvl;
  assign rx_sample = rx_half & rx_phase_q;
  assign rx_fin = (rx_state_q == RX_STOP) && rx_sample;
  assign brk_ok = (rx_state_q == RX_BRK) && rx_sample && rx_lvl && brk_low_q >= BRK_RX_MIN;
  assign brk_fail = (rx_state_q == RX_BRK) && rx_sample && rx_lvl && brk_low_q < BRK_RX_MIN;

  always_comb begin
    pe = 1'b0;
    if (par_mode == PAR_ODD) begin
      pe = ~rx_par_q; // R3
    end else if (par_mode == PAR_EVEN) begin
      pe = rx_par_q;
    end
  end
  assign rx_err = {pe, ~rx_lvl, rx_full_q}; // R4 R5

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_prev_q <= 1'b1;
      rx_state_q <= RX_IDLE;
      rx_phase_q <= 1'b0;
      rx_bits_q <= 4'h0;
      rx_par_q <= 1'b0;
      rx_shift_reg_q <= 8'h0;
      brk_low_q <= 4'h0;
    end else begin
      rx_prev_q <= rx_lvl;
      if (rx_half) begin
        rx_phase_q <= ~rx_phase_q;
      end
      if (!rx_en) begin
        rx_state_q <= RX_IDLE;
      end else begin
        case (rx_state_q)
          RX_IDLE: begin
            if (rx_fall) begin
              rx_state_q <= RX_START;
              rx_phase_q <= 1'b0;
            end
          end
          RX_START: begin
            if (rx_half) begin
              rx_phase_q <= 1'b0;
              rx_bits_q <= 4'h0;
              rx_par_q <= 1'b0;
              brk_low_q <= 4'h1;
              if (rx_lvl) begin
                rx_state_q <= RX_IDLE; // R26
              end else if (uart_control_reg_q[CTRL_BRK_RX]) begin
                rx_state_q <= RX_BRK;
              end else begin
                rx_state_q <= RX_DATA;
              end
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_shift_reg_q <= {rx_lvl, rx_shift_reg_q[7:1]};
              rx_par_q <= rx_par_q ^ rx_lvl;
              rx_bits_q <= rx_bits_q + 4'h1;
              if (rx_bits_q == DATA_LAST) begin
                rx_state_q <= (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
              end
            end
          end
          RX_PAR: begin
            if (rx_sample) begin
              rx_par_q <= rx_par_q ^ rx_lvl;
              rx_state_q <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_sample) begin
              rx_state_q <= RX_IDLE; // R25
            end
          end
          RX_BRK: begin
            if (rx_sample) begin
              if (rx_lvl) begin
                rx_state_q <= RX_IDLE; // R17
              end else if (brk_low_q != 4'hf) begin
                brk_low_q <= brk_low_q + 4'h1;
              end
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // buffer and error status; new error flags win over the status read clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_buffer_reg_q <= RXBUF_RST;
      rx_full_q <= 1'b0;
      rx_error_status_reg_q <= 3'h0;
    end else begin
      if (rx_fin && !rx_full_q) begin
        rx_buffer_reg_q <= rx_shift_reg_q; // R5 R16
      end
      rx_full_q <= (rx_fin & ~rx_full_q) | (rx_full_q & ~(rd && hit(paddr_i, ADDR_RXBUF)));
      rx_error_status_reg_q <= (rd && hit(paddr_i, ADDR_ERR) ? 3'h0 : rx_error_status_reg_q) | // R2
        (rx_fin ? rx_err : 3'h0); // R1 R15
    end
  end

  // event pulses, one cycle after the deciding sample
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_done_irq_o <= 1'b0;
      rx_error_irq_o <= 1'b0;
    end else begin
      rx_done_irq_o <= (rx_fin && (merge || rx_err == 3'h0)) || brk_ok; // R6 R14
      rx_error_irq_o <= rx_fin && rx_err != 3'h0 && !merge; // R1 R6
    end
  end

  // transmit framing
  assign brk_len = BRK_TX_BASE + {1'b0, uart_control_reg_q[CTRL_LEN_HI:CTRL_LEN_LO]}; // R10
  assign tx_bit_end = tx_half & tx_phase_q;
  assign tx_stop_end = (tx_state_q == TX_STOP) && tx_bit_end &&
    (!uart_mode_reg_q[MODE_STOP2] || tx_bits_q == 4'h1);
  assign tx_load = tx_en && tx_full_q && (tx_state_q == TX_IDLE || tx_stop_end);
  assign brk_go = tx_en && tx_state_q == TX_IDLE && !tx_full_q && uart_control_reg_q[CTRL_BRK_TX];
  assign tx_done = tx_stop_end || (tx_state_q == TX_BRK && tx_bit_end && tx_bits_q == brk_len - 4'h1);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_buffer_reg_q <= 8'h0;
      tx_full_q <= 1'b0;
    end else if (wr && hit(paddr_i, ADDR_TXBUF) && tx_en) begin
      tx_buffer_reg_q <= pwdata_i[7:0];
      tx_full_q <= 1'b1;
    end else if (tx_load || !tx_en) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_state_q <= TX_IDLE;
      tx_phase_q <= 1'b0;
      tx_bits_q <= 4'h0;
      tx_shift_q <= 8'h0;
      tx_par_q <= 1'b0;
    end else if (!tx_en) begin
      tx_state_q <= TX_IDLE;
      tx_phase_q <= 1'b0;
    end else if (tx_load || brk_go) begin
      tx_state_q <= tx_load ? TX_START : TX_BRK; // R11 R22
      tx_phase_q <= 1'b0;
      tx_bits_q <= 4'h0;
      tx_shift_q <= tx_buffer_reg_q;
      tx_par_q <= ^tx_buffer_reg_q;
    end else begin
      if (tx_half) begin
        tx_phase_q <= ~tx_phase_q;
      end
      if (tx_bit_end) begin
        tx_bits_q <= tx_bits_q + 4'h1;
        case (tx_state_q)
          TX_START: begin
            tx_state_q <= TX_DATA;
            tx_bits_q <= 4'h0;
          end
          TX_DATA: begin
            tx_shift_q <= {1'b1, tx_shift_q[7:1]};
            if (tx_bits_q == DATA_LAST) begin
              tx_state_q <= (par_mode == PAR_NONE) ? TX_STOP : TX_PAR;
              tx_bits_q <= 4'h0;
            end
          end
          TX_PAR: begin
            tx_state_q <= TX_STOP;
            tx_bits_q <= 4'h0;
          end
          TX_STOP, TX_BRK: begin
            if (tx_done) begin
              tx_state_q <= TX_IDLE; // R22
            end
          end
          default: tx_state_q <= TX_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_state_q)
      TX_START: tx_out = 1'b0;
      TX_DATA: tx_out = tx_shift_q[0];
      TX_PAR: tx_out = (par_mode == PAR_ODD) ? ~tx_par_q : (par_mode == PAR_EVEN) & tx_par_q;
      TX_BRK: tx_out = 1'b0;
      default: tx_out = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_out_pin_o <= 1'b1;
      tx_done_irq_o <= 1'b0;
    end else begin
      serial_out_pin_o <= tx_out;
      tx_done_irq_o <= tx_done; // R11
    end
  end

  // checks
  sequence s_err_fin;
    rx_fin && rx_err != 3'h0;
  endsequence
  sequence s_brk_end;
    rx_state_q == RX_BRK && rx_sample && rx_lvl;
  endsequence

  err_irq_split_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    s_err_fin and !merge |=> rx_error_irq_o && !rx_done_irq_o) else $error("error pulse misrouted");
  err_irq_merge_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    s_err_fin and merge |=> rx_done_irq_o && !rx_error_irq_o) else $error("merged error misrouted");
  err_read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    rd && hit(paddr_i, ADDR_ERR) && !rx_fin |=> rx_error_status_reg_q == 3'h0) else $error("status not cleared");
  overrun_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    rx_fin && rx_full_q |=> rx_error_status_reg_q[ERR_OVE] && $stable(rx_buffer_reg_q))
    else $error("overrun mishandled");
  brk_long_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    s_brk_end and brk_low_q >= BRK_RX_MIN |=> rx_done_irq_o && !uart_control_reg_q[CTRL_BRK_RX] &&
      !uart_control_reg_q[CTRL_BRK_FLAG]) else $error("long break not completed");
  brk_short_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    s_brk_end and brk_low_q < BRK_RX_MIN |=> !rx_done_irq_o && uart_control_reg_q[CTRL_BRK_RX])
    else $error("short break mishandled");
  brk_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    s_brk_end and !(rd && hit(paddr_i, ADDR_ERR)) |=> $stable(rx_error_status_reg_q) &&
      $stable(rx_buffer_reg_q)) else $error("break touched status or buffer");
  tx_brk_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    tx_state_q == TX_BRK |=> !serial_out_pin_o) else $error("break not driven low");
  base_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    !uart_power_on |-> !base_tick ##1 !rx_half && !tx_half) else $error("base clock ran unpowered");
  start_reject_a: assert property (@(posedge clk_i) disable iff (rst_i) // R26
    rx_state_q == RX_START && rx_half && rx_lvl |=> rx_state_q == RX_IDLE) else $error("false start taken");
endmodule

/* File: ube_node.sv */
`timescale 1ns/100ps
module ube_node #(
  parameter int BIT = 16
) (
  // clock
  input wire logic clk_i,
  // line toward the device
  output logic line_o
);
  initial line_o = 1'b1;
  // bits go out lsb first; the line idles high between frames
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (BIT) @(posedge clk_i) line_o <= bits[i];
    end
    @(posedge clk_i) line_o <= 1'b1;
  endtask
  // one clock of low, shorter than the filter accepts
  task automatic glitch();
    @(posedge clk_i) line_o <= 1'b0;
    @(posedge clk_i) line_o <= 1'b1;
  endtask
endmodule

/* File: ube_uart_tb.sv */
`timescale 1ns/100ps
module ube_uart_tb;
  import ube_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic psel_i = 0;
  logic penable_i = 0;
  logic pwrite_i = 0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, se, ser_in, ser_out, rxd, rxe, txd;
  logic [7:0] d, q[$];
  int fails = 0, n_checks = 0, n_rxd = 0, n_rxe = 0, n_txd = 0, seed = 42308, w;
  always #50 clk_i = ~clk_i;
  ube_uart dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_in_pin_i(ser_in),
    .serial_out_pin_o(ser_out), .rx_done_irq_o(rxd), .rx_error_irq_o(rxe), .tx_done_irq_o(txd));
  ube_node node (.clk_i(clk_i), .line_o(ser_in));
  // pulses are one cycle wide, so count them at every edge
  always @(posedge clk_i) begin
    if (rxd === 1'b1) n_rxd++;
    if (rxe === 1'b1) n_rxe++;
    if (txd === 1'b1) n_txd++;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i) penable_i <= 1'b1;
    w = 0;
    do begin
      @(posedge clk_i);
      w++;
    end while (pready_o !== 1'b1 && w < 50);
    rd = prdata_o;
    se = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  // start, data lsb first, parity, stop
  task automatic frame(input logic [7:0] b, input logic p, input logic s);
    node.send({5'h1f, s, p, b, 1'b0}, 11);
    repeat (40) @(posedge clk_i);
  endtask
  // waits for the transmit line to fall, then counts the clocks it stays low
  task automatic low_len(output int n);
    int t;
    t = 0;
    while (ser_out !== 1'b0 && t < 500) begin
      @(posedge clk_i);
      t++;
    end
    n = 0;
    while (ser_out === 1'b0 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    if (t >= 500 || n >= 500) begin
      fails++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("mode", ADDR_MODE, MODE_RST);
    rdc("ctrl", ADDR_CTRL, CTRL_RST);
    rdc("rxbuf", ADDR_RXBUF, RXBUF_RST);
    rdc("div", ADDR_DIV, DIV_RST);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    apb(1'b1, ADDR_DIV, 32'h7);
    rdc("div", ADDR_DIV, DIV_RST);
    apb(1'b1, ADDR_DIV, {24'h0, DIV_MIN});
    apb(1'b1, ADDR_CLKSEL, 32'h0);
    apb(1'b1, ADDR_MODE, 32'hf8);
    repeat (40) @(posedge clk_i);
    apb(1'b1, ADDR_CTRL, 32'h54);
    rdc("ctrl", ADDR_CTRL, 32'hd4);
    node.send(16'h0200, 10);
    repeat (40) @(posedge clk_i);
    chk("n_rxd", 0, n_rxd);
    rdc("ctrl", ADDR_CTRL, 32'hd4);
    node.send(16'h1000, 13);
    repeat (40) @(posedge clk_i);
    chk("n_rxd", 1, n_rxd);
    rdc("ctrl", ADDR_CTRL, CTRL_RST);
    rdc("err", ADDR_ERR, 32'h0);
    rdc("rxbuf", ADDR_RXBUF, RXBUF_RST);
    node.glitch();
    repeat (100) @(posedge clk_i);
    chk("n_rxd", 1, n_rxd);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      // the second byte meets a full buffer and is lost
      if (i == 0) begin
        q.push_back(d);
      end
      frame(d, ^d, 1'b1);
    end
    chk("n_rxd", 2, n_rxd);
    chk("n_rxe", 1, n_rxe);
    rdc("rxbuf", ADDR_RXBUF, q.pop_front());
    d = $random(seed);
    q.push_back(d);
    frame(d, ^d, 1'b1);
    chk("n_rxd", 3, n_rxd);
    chk("n_rxe", 1, n_rxe);
    rdc("err", ADDR_ERR, 32'h1);
    rdc("err", ADDR_ERR, 32'h0);
    rdc("rxbuf", ADDR_RXBUF, q.pop_front());
    frame(d, ~^d, 1'b1);
    chk("n_rxe", 2, n_rxe);
    rdc("err", ADDR_ERR, 32'h4);
    rdc("rxbuf", ADDR_RXBUF, d);
    apb(1'b1, ADDR_MODE, 32'hf9);
    frame(d, ^d, 1'b0);
    chk("n_rxd", 4, n_rxd);
    chk("n_rxe", 2, n_rxe);
    rdc("err", ADDR_ERR, 32'h2);
    rdc("rxbuf", ADDR_RXBUF, d);
    apb(1'b1, ADDR_CTRL, 32'h34);
    low_len(w);
    chk("brk_len", 32'(13 * 2 * DIV_MIN), w);
    repeat (5) @(posedge clk_i);
    chk("n_txd", 1, n_txd);
    rdc("ctrl", ADDR_CTRL, CTRL_RST);
    // zero byte with even parity: ten low bit times
    apb(1'b1, ADDR_TXBUF, 32'h0);
    low_len(w);
    chk("tx_low", 32'(10 * 2 * DIV_MIN), w);
    repeat (40) @(posedge clk_i);
    chk("n_txd", 2, n_txd);
    // odd parity with merged errors
    apb(1'b1, ADDR_MODE, 32'hf1);
    d = $random(seed);
    frame(d, ~^d, 1'b1);
    chk("n_rxd", 5, n_rxd);
    rdc("err", ADDR_ERR, 32'h0);
    rdc("rxbuf", ADDR_RXBUF, d);
    end_of_test();
  end
endmodule
